// *** include/bmc_pkg.sv ***
// Constants and types shared by the backup mode controller
`default_nettype none
package bmc_pkg;
   // ----------------------------------------
   // Port codes seen on the port bus
   // ----------------------------------------
   localparam logic [3:0] BMC_CODE_MODE = 4'he; // Stop mode select port
   localparam logic [3:0] BMC_CODE_HOLD = 4'hb; // Backup request pin port
   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int BMC_MODE_BIT = 0; // Stop mode select bit in data
   localparam int BMC_HOLD_BIT = 0; // Pin level in read data
   localparam int BMC_STATE_LSB = 1; // Halt-state flag in read data
   localparam logic BMC_MODE_RST = 1'b0; // Gated stop after reset
   // ----------------------------------------
   // Wait instruction operands
   // ----------------------------------------
   localparam logic [3:0] BMC_WAIT_SOFT_OP = 4'h0; // CPU-only halt
   localparam logic [3:0] BMC_WAIT_DEEP_OP = 4'h1; // Deep halt
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int BMC_CLK_HZ = 100_000_000; // Rate of ref_clk
   localparam int BMC_STANDBY_MS = 100; // Stand-by after clock stop
   localparam int BMC_STANDBY_CYC = (BMC_CLK_HZ / 1000) * BMC_STANDBY_MS;
   localparam int BMC_CNT_W = 24; // Wide enough for the stand-by count
   // ----------------------------------------
   // Controller states
   // ----------------------------------------
   typedef enum logic [2:0] {
      BMC_ST_RUN,
      BMC_ST_CLKSTOP,
      BMC_ST_STANDBY,
      BMC_ST_WAIT_SOFT,
      BMC_ST_WAIT_DEEP
   } bmc_state_t;
endpackage
`default_nettype wire

// *** logic/bmc_backup_ctrl.sv ***
// Backup mode controller: clock stop, wait halts, wake-up and resume
//
// Contract
// - Stop or wait instruction enters a backup mode
// - Clock stop halts oscillator, forces outputs off
// - Clock stop resumes after 100 ms stand-by
// - Mode bit written by port write code EH
// - Gated stop enters only with pin low
// - Forced stop always enters clock stop
// - PLL off while stop instruction executes
// - Gated stop released by pin high, input change
// - Forced stop released by pin or input change
// - Wait resumes immediately, no stand-by
// - Wait operand 0H halts CPU only
// - Wait operand 1H deep halt, display low
// - PLL off in deep halt only; the code also holds it off in clock stop and stand-by
// - Wait released by pin or input change
// - Key high releases wait in key mode
// - 2 Hz flag releases CPU-only halt
// - Pin level readable at port code BH
// - Mode bit clears to gated after reset
//
// The implementer's own choices: the register offsets and the strobed register port.
`default_nettype none
module bmc_backup_ctrl
   import bmc_pkg::*;
#(
   parameter int unsigned STANDBY_CYCLES = BMC_STANDBY_CYC
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [3:0] port_addr,
   input wire logic [3:0] port_wdata,
   input wire logic port_wr,
   input wire logic port_rd,
   output logic [3:0] port_rdata,
   input wire logic stop_clock_instr,
   input wire logic wait_instr,
   input wire logic [3:0] wait_operand,
   input wire logic backup_req_n,
   input wire logic [3:0] key_input_pins,
   input wire logic [3:0] wake_io_port_bits,
   input wire logic [3:0] wake_io_is_input,
   input wire logic key_input_mode,
   input wire logic timer_2hz_flag,
   output logic osc_run,
   output logic pll_off,
   output logic disp_force_low,
   output logic out_port_force_off,
   output logic cpu_halt,
   output logic resume_pulse
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   bmc_state_t state_reg; // Current backup state
   bmc_state_t state_next; // Next backup state
   logic stop_mode_select_bit; // 0 gated, 1 forced
   logic forced_reg; // Mode latched at clock stop entry
   logic [3:0] snap_io_reg; // Wake port levels at entry
   logic snap_hold_reg; // Pin level at entry
   logic flag_d_reg; // Last 2 Hz flag value
   logic [BMC_CNT_W-1:0] cnt_reg; // Stand-by countdown
   logic resume_reg; // One-cycle resume strobe
   logic [3:0] rdata_reg; // Read data, valid one cycle
   logic [8:0] pins_s; // Synchronised pin group
   logic hold_s; // Pin level, 1 = high
   logic [3:0] key_s; // Synchronised keys
   logic [3:0] io_s; // Synchronised wake port bits
   wire in_run; // CPU executing
   wire stop_enter; // Stop instruction takes effect
   wire soft_enter; // CPU-only halt requested
   wire deep_enter; // Deep halt requested
   wire io_change; // Input-configured bit moved
   wire hold_change; // Pin moved since entry
   wire key_wake; // Key pressed in key mode
   wire flag_rise; // 2 Hz flag just set
   wire stop_wake; // Clock stop release
   wire wait_wake; // Wait release
   wire snap_load; // Take entry snapshot
   wire wr_mode; // Write to mode port
   wire [3:0] rd_mux; // Read decode
   wire [BMC_CNT_W-1:0] cnt_load; // Stand-by reload value

   // ----------------------------------------
   // Pin synchronisation
   // ----------------------------------------
   // Pins come from outside the clock domain
   bmc_sync2 #(
      .WIDTH(9)
   ) u_sync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .async_in({backup_req_n, key_input_pins, wake_io_port_bits}),
      .sync_out(pins_s)
   );
   assign hold_s = pins_s[8];
   assign key_s = pins_s[7:4];
   assign io_s = pins_s[3:0];

   // ----------------------------------------
   // Entry decode
   // ----------------------------------------
   assign in_run = (state_reg == BMC_ST_RUN);
   // Gated needs the pin low; forced ignores it
   assign stop_enter = in_run && stop_clock_instr && (stop_mode_select_bit || !hold_s);
   // Operand picks the halt depth; other operands do nothing
   assign soft_enter = in_run && wait_instr && !stop_clock_instr && (wait_operand == BMC_WAIT_SOFT_OP);
   assign deep_enter = in_run && wait_instr && !stop_clock_instr && (wait_operand == BMC_WAIT_DEEP_OP);
   assign snap_load = stop_enter || soft_enter || deep_enter;

   // ----------------------------------------
   // Wake decode
   // ----------------------------------------
   // Only bits set as inputs count, against entry levels
   assign io_change = |((io_s ^ snap_io_reg) & wake_io_is_input);
   assign hold_change = hold_s ^ snap_hold_reg;
   assign key_wake = key_input_mode && (|key_s);
   assign flag_rise = timer_2hz_flag && !flag_d_reg;
   // Gated: pin high; forced: pin activity
   assign stop_wake = (forced_reg ? hold_change : hold_s) || io_change;
   // 2 Hz wake only in the CPU-only halt
   assign wait_wake = hold_change || io_change || key_wake || ((state_reg == BMC_ST_WAIT_SOFT) && flag_rise);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         BMC_ST_RUN:
         begin
            // Stop wins if both instructions appear at once
            if (stop_enter)
               state_next = BMC_ST_CLKSTOP;
            else if (soft_enter)
               state_next = BMC_ST_WAIT_SOFT;
            else if (deep_enter)
               state_next = BMC_ST_WAIT_DEEP;
         end
         BMC_ST_CLKSTOP:
         begin
            if (stop_wake)
               state_next = BMC_ST_STANDBY;
         end
         BMC_ST_STANDBY:
         begin
            // Oscillator settles before code runs again
            if (cnt_reg == '0)
               state_next = BMC_ST_RUN;
         end
         BMC_ST_WAIT_SOFT, BMC_ST_WAIT_DEEP:
         begin
            // No stand-by on wait release
            if (wait_wake)
               state_next = BMC_ST_RUN;
         end
         default:
            state_next = BMC_ST_RUN;
      endcase
   end

   // ----------------------------------------
   // State register and resume strobe
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= BMC_ST_RUN;
         resume_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         // PC moves to the next address on this strobe
         resume_reg <= !in_run && (state_next == BMC_ST_RUN);
      end
   end

   // ----------------------------------------
   // Entry snapshot
   // ----------------------------------------
   // Taken on the entry edge, so a change right after entry still wakes
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         snap_io_reg <= 4'h0;
         snap_hold_reg <= 1'b0;
         forced_reg <= 1'b0;
         flag_d_reg <= 1'b0;
      end
      else
      begin
         flag_d_reg <= timer_2hz_flag;
         if (snap_load)
         begin
            snap_io_reg <= io_s;
            snap_hold_reg <= hold_s;
            forced_reg <= stop_mode_select_bit;
         end
      end
   end

   // ----------------------------------------
   // Stand-by counter
   // ----------------------------------------
   // Shorten STANDBY_CYCLES in simulation; hardware uses the full 100 ms
   assign cnt_load = BMC_CNT_W'(STANDBY_CYCLES - 1);
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         cnt_reg <= '0;
      else if (state_reg == BMC_ST_CLKSTOP)
         cnt_reg <= cnt_load;
      else if (state_reg == BMC_ST_STANDBY && cnt_reg != '0)
         cnt_reg <= cnt_reg - 1'b1;
   end

   // ----------------------------------------
   // Port bus
   // ----------------------------------------
   assign wr_mode = port_wr && (port_addr == BMC_CODE_MODE);
   // Read decode; unmapped codes read zero
   assign rd_mux = (port_addr == BMC_CODE_HOLD) ? {2'b00, !in_run, hold_s} :
                   (port_addr == BMC_CODE_MODE) ? {3'b000, stop_mode_select_bit} : 4'h0;

   // Mode bit, gated after reset
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         stop_mode_select_bit <= BMC_MODE_RST;
      else if (wr_mode)
         stop_mode_select_bit <= port_wdata[BMC_MODE_BIT];
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata_reg <= 4'h0;
      else if (port_rd)
         rdata_reg <= rd_mux;
      else
         rdata_reg <= 4'h0;
   end
   assign port_rdata = rdata_reg;

   // ----------------------------------------
   // Control outputs
   // ----------------------------------------
   // Crystal stops only in clock stop; it restarts for the stand
   assign osc_run = (state_reg != BMC_ST_CLKSTOP);
   // Off during the stop instruction and deep halt, not soft halt
   assign pll_off = (in_run && stop_clock_instr) || (state_reg == BMC_ST_CLKSTOP) ||
                    (state_reg == BMC_ST_STANDBY) || (state_reg == BMC_ST_WAIT_DEEP);
   assign disp_force_low = (state_reg == BMC_ST_CLKSTOP) || (state_reg == BMC_ST_WAIT_DEEP);
   assign out_port_force_off = (state_reg == BMC_ST_CLKSTOP);
   assign cpu_halt = !in_run; // PC held at the halting instruction
   assign resume_pulse = resume_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   a_gated_no_operation: assert property (in_run && stop_clock_instr && !stop_mode_select_bit && hold_s
      |=> state_reg == BMC_ST_RUN && !resume_pulse) else $error("gated stop entered with pin high");
   a_gated_enter: assert property (in_run && stop_clock_instr && !stop_mode_select_bit && !hold_s
      |=> state_reg == BMC_ST_CLKSTOP) else $error("gated stop not entered");
   a_forced_enter: assert property (in_run && stop_clock_instr && stop_mode_select_bit
      |=> state_reg == BMC_ST_CLKSTOP) else $error("forced stop not entered");
   a_stop_outputs: assert property (state_reg == BMC_ST_CLKSTOP
      |-> !osc_run && out_port_force_off && disp_force_low && pll_off) else $error("stop outputs wrong");
   a_pll_instr: assert property (in_run && stop_clock_instr |-> pll_off)
      else $error("pll on during stop instruction");
   a_soft_halt: assert property (state_reg == BMC_ST_WAIT_SOFT
      |-> osc_run && !pll_off && !disp_force_low) else $error("soft halt outputs wrong");
   a_deep_halt: assert property (state_reg == BMC_ST_WAIT_DEEP
      |-> osc_run && pll_off && disp_force_low && cpu_halt) else $error("deep halt outputs wrong");
   a_standby_hold: assert property (state_reg == BMC_ST_STANDBY && cnt_reg != '0
      |=> state_reg == BMC_ST_STANDBY && cnt_reg == $past(cnt_reg) - 1'b1) else $error("stand-by cut short");
   a_standby_end: assert property ($rose(state_reg == BMC_ST_STANDBY)
      |-> cnt_reg == cnt_load ##0 (!resume_pulse throughout (state_reg == BMC_ST_STANDBY)[*1]))
      else $error("stand-by length wrong");
   a_flag_wake: assert property (state_reg == BMC_ST_WAIT_SOFT && flag_rise && !wait_instr
      |=> in_run && resume_pulse) else $error("2 Hz flag did not release soft halt");
   a_deep_noflag: assert property (state_reg == BMC_ST_WAIT_DEEP && flag_rise && !hold_change
      && !io_change && !key_wake |=> state_reg == BMC_ST_WAIT_DEEP) else $error("2 Hz flag released deep halt");
   a_key_wake: assert property ((state_reg == BMC_ST_WAIT_SOFT || state_reg == BMC_ST_WAIT_DEEP)
      && key_wake |=> in_run ##1 !resume_pulse) else $error("key did not release wait");
   a_io_wake: assert property (state_reg == BMC_ST_CLKSTOP && io_change
      |=> state_reg == BMC_ST_STANDBY) else $error("input change did not release stop");
   a_mode_write: assert property (wr_mode |=> stop_mode_select_bit == $past(port_wdata[BMC_MODE_BIT]))
      else $error("mode bit not written");
   a_pin_read: assert property (port_rd && port_addr == BMC_CODE_HOLD
      |=> port_rdata[BMC_HOLD_BIT] == $past(hold_s) ##1 port_rdata == 4'h0 || $past(port_rd))
      else $error("pin read data wrong");

   c_stop_cycle: cover property (state_reg == BMC_ST_STANDBY ##1 in_run);
   c_soft_flag: cover property (state_reg == BMC_ST_WAIT_SOFT && flag_rise);
   c_deep_key: cover property (state_reg == BMC_ST_WAIT_DEEP && key_wake);
   c_gated_no_operation: cover property (in_run && stop_clock_instr && !stop_enter);
endmodule // bmc_backup_ctrl
`default_nettype wire

// *** logic/bmc_sync2.sv ***
// Two-flop synchroniser for asynchronous pin inputs
`default_nettype none
module bmc_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // First stage, read only by the second stage
   logic [WIDTH-1:0] meta_reg;

   // ----------------------------------------
   // Synchroniser chain
   // ----------------------------------------
   // Both stages clear on reset; a level is trusted two edges later
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule // bmc_sync2
`default_nettype wire

// *** tb/bmc_far_model.sv ***
// Far-side pin model: backup request pin, key pins, wake port bits, 2 Hz flag
`default_nettype none
module bmc_far_model (
   input wire logic ref_clk,
   output logic backup_req_n,
   output logic [3:0] key_input_pins,
   output logic [3:0] wake_io_port_bits,
   output logic timer_2hz_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Pin levels at power-up
   // ----------------------------------------
   initial
   begin
      backup_req_n = 1'b1; // Supply present, pin high
      key_input_pins = 4'h0; // No key pressed
      wake_io_port_bits = 4'h0;
      timer_2hz_flag = 1'b0;
   end
   // ----------------------------------------
   // Pin changes, always just after an edge
   // ----------------------------------------
   // All four move together so a scenario states the whole far side at once
   task automatic set_pins(input logic hold, input logic [3:0] keys, input logic [3:0] wake, input logic flag);
      @(posedge ref_clk);
      backup_req_n <= hold;
      key_input_pins <= keys;
      wake_io_port_bits <= wake;
      timer_2hz_flag <= flag;
   endtask
endmodule // bmc_far_model
`default_nettype wire

// *** tb/test_backup_mode_controller.sv ***
// Self-checking bench for the backup mode controller
`default_nettype none
module test_backup_mode_controller;
   timeunit 1ns;
   timeprecision 1ps;
   import bmc_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   localparam int SB = 20; // Short stand-by so the run stays brief
   logic ref_clk, arst_n, port_wr, port_rd, stop_clock_instr, wait_instr;
   logic [3:0] port_addr, port_wdata, port_rdata, wait_operand, wake_io_is_input;
   logic backup_req_n, key_input_mode, timer_2hz_flag;
   logic [3:0] key_input_pins, wake_io_port_bits;
   logic osc_run, pll_off, disp_force_low, out_port_force_off, cpu_halt, resume_pulse;
   logic [3:0] d;
   logic p;
   int n, fail_count, compares;
   // ----------------------------------------
   // Design and far side
   // ----------------------------------------
   bmc_backup_ctrl #(.STANDBY_CYCLES(SB)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .port_addr(port_addr),
      .port_wdata(port_wdata), .port_wr(port_wr), .port_rd(port_rd), .port_rdata(port_rdata),
      .stop_clock_instr(stop_clock_instr), .wait_instr(wait_instr), .wait_operand(wait_operand),
      .backup_req_n(backup_req_n), .key_input_pins(key_input_pins), .wake_io_port_bits(wake_io_port_bits),
      .wake_io_is_input(wake_io_is_input), .key_input_mode(key_input_mode), .timer_2hz_flag(timer_2hz_flag),
      .osc_run(osc_run), .pll_off(pll_off), .disp_force_low(disp_force_low),
      .out_port_force_off(out_port_force_off), .cpu_halt(cpu_halt), .resume_pulse(resume_pulse));
   bmc_far_model far (.ref_clk(ref_clk), .backup_req_n(backup_req_n), .key_input_pins(key_input_pins),
      .wake_io_port_bits(wake_io_port_bits), .timer_2hz_flag(timer_2hz_flag));
   // ----------------------------------------
   // Clock, 100 MHz
   // ----------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic conclude();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [3:0] v);
      @(posedge ref_clk);
      port_wr <= 1'b1;
      port_addr <= a;
      port_wdata <= v;
      @(posedge ref_clk);
      port_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [3:0] v);
      @(posedge ref_clk);
      port_rd <= 1'b1;
      port_addr <= a;
      @(posedge ref_clk);
      port_rd <= 1'b0;
      #1;
      v = port_rdata;
   endtask
   // One-cycle instruction pulse; PLL state sampled inside that cycle
   task automatic instr(input logic s, input logic w, input logic [3:0] op, output logic pl);
      @(posedge ref_clk);
      stop_clock_instr <= s;
      wait_instr <= w;
      wait_operand <= op;
      #1;
      pl = pll_off;
      @(posedge ref_clk);
      stop_clock_instr <= 1'b0;
      wait_instr <= 1'b0;
      #1;
   endtask
   // Bounded wait for the halt to end; a hang goes straight to the report
   task automatic wake(input int lim, output int k);
      k = 0;
      while (cpu_halt !== 1'b0)
      begin
         if (k == lim)
         begin
            fail_count++;
            conclude();
         end
         @(posedge ref_clk);
         #1;
         k++;
      end
      chk(resume_pulse, 1'b1);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      fail_count = 0;
      compares = 0;
      arst_n = 1'b0;
      {port_wr, port_rd, stop_clock_instr, wait_instr, key_input_mode} = 5'h00;
      port_addr = 4'h0;
      port_wdata = 4'h0;
      wait_operand = 4'h0;
      wake_io_is_input = 4'h1; // Only bit0 may wake
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      tick(3); // Pin synchroniser settles
      rd(BMC_CODE_MODE, d);
      chk(d, 4'h0);
      chk({osc_run, pll_off, disp_force_low, out_port_force_off, cpu_halt}, 5'h10);
      rd(BMC_CODE_HOLD, d);
      chk(d, 4'h1);
      // Gated stop with pin high acts as no-operation
      instr(1'b1, 1'b0, 4'h0, p);
      chk(p, 1'b1);
      chk(cpu_halt, 1'b0);
      // Gated stop with pin low; pin port read first
      far.set_pins(1'b0, 4'h0, 4'h0, 1'b0);
      tick(3);
      rd(BMC_CODE_HOLD, d);
      chk(d, 4'h0);
      instr(1'b1, 1'b0, 4'h0, p);
      chk({osc_run, disp_force_low, out_port_force_off, cpu_halt}, 4'h7);
      chk(pll_off, 1'b1);
      // Pin port while halted: halt flag set, pin still low
      rd(BMC_CODE_HOLD, d);
      chk(d, 4'h2);
      far.set_pins(1'b0, 4'h0, 4'h2, 1'b0); // Output-configured bit moves
      tick(4);
      chk(cpu_halt, 1'b1);
      far.set_pins(1'b1, 4'h0, 4'h2, 1'b0);
      wake(SB + 10, n);
      // Two synchroniser edges, one wake edge, then the full stand-by
      chk(8'(n), 8'(SB + 3));
      chk(osc_run, 1'b1);
      // Forced stop with pin high, released by an input bit
      wr(BMC_CODE_MODE, 4'h1);
      rd(BMC_CODE_MODE, d);
      chk(d, 4'h1);
      instr(1'b1, 1'b0, 4'h0, p);
      tick(4);
      chk({osc_run, cpu_halt}, 2'h1);
      far.set_pins(1'b1, 4'h0, 4'h3, 1'b0);
      wake(SB + 10, n);
      // Forced stop released by the pin falling
      instr(1'b1, 1'b0, 4'h0, p);
      chk(cpu_halt, 1'b1);
      far.set_pins(1'b0, 4'h0, 4'h3, 1'b0);
      wake(SB + 10, n);
      // CPU-only halt, woken by the 2 Hz flag
      instr(1'b0, 1'b1, BMC_WAIT_SOFT_OP, p);
      chk({osc_run, pll_off, disp_force_low, cpu_halt}, 4'h9);
      far.set_pins(1'b0, 4'h0, 4'h3, 1'b1);
      wake(5, n);
      chk(n <= 3, 1'b1);
      // Deep halt: flag ignored, keys wake only in key mode
      far.set_pins(1'b0, 4'h0, 4'h3, 1'b0);
      instr(1'b0, 1'b1, BMC_WAIT_DEEP_OP, p);
      chk({osc_run, pll_off, disp_force_low, out_port_force_off, cpu_halt}, 5'h1d);
      far.set_pins(1'b0, 4'h8, 4'h3, 1'b1);
      tick(4);
      chk(cpu_halt, 1'b1);
      @(posedge ref_clk);
      key_input_mode <= 1'b1;
      wake(8, n);
      // CPU-only halt woken by a pin change
      far.set_pins(1'b0, 4'h0, 4'h3, 1'b0);
      instr(1'b0, 1'b1, BMC_WAIT_SOFT_OP, p);
      far.set_pins(1'b1, 4'h0, 4'h3, 1'b0);
      wake(8, n);
      // Unknown wait operand does nothing
      instr(1'b0, 1'b1, 4'h2, p);
      tick(2);
      chk(cpu_halt, 1'b0);
      conclude();
   end
endmodule // test_backup_mode_controller
`default_nettype wire
